/* File: verilog/etxf_core.sv */
/*
 * e3 transmit framer timing source select and maintenance byte far-end error control.
 * assumes an ahb-lite master on i_mclk, line clocks slower than i_mclk / 4,
 * and receive framer error-monitor results arriving on i_mclk.
 */
// What this block does
// - config bit 0 set: far-end error bit follows receive error-monitor results.
// - timing select bits 1:0: 11 free-run, 01 frame reference, 00 loop timing.
// - free-run: count line clock ticks, frame starts on own schedule.
// - frame reference mode: line clock ticks, rising reference edge restarts frame.
// - loop timing: recovered clock ticks, ignores any external reference.
// - config bit 0 clear: software maintenance byte goes into each frame.
// - config bit 0 clear: software byte bit 6 becomes outbound maintenance byte bit 2.
// - automatic: erred received frame gives bit 1 in next frame, clean gives 0.
`timescale 1ns/100ps
module etxf_core (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_reset_n,
    // ahb-lite slave
    input  wire logic                 i_hsel,
    input  wire logic [31:0]          i_haddr,
    input  wire logic [1:0]           i_htrans,
    input  wire logic                 i_hwrite,
    input  wire logic [2:0]           i_hsize,
    input  wire logic [31:0]          i_hwdata,
    input  wire logic                 i_hready,
    output logic      [31:0]          o_hrdata,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    // timing pins
    input  wire logic                 i_tx_line_clock_in,
    input  wire logic                 i_rx_recovered_clock,
    input  wire logic                 i_tx_frame_sync_in,
    // receive framer error-monitor result
    input  wire logic                 i_rx_errmon_done,
    input  wire logic                 i_rx_errmon_err,
    // outbound frame
    output logic                      o_frame_start,
    output logic [etxf_pkg::ETXF_CNT_W-1:0] o_bit_count,
    output logic                      o_far_end_block_error_bit,
    output logic                      o_timing_loop,
    // maintenance byte stream
    output logic                      o_mnt_valid,
    output logic [7:0]                o_maintenance_byte,
    input  wire logic                 i_mnt_ready
);
    import etxf_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                  line_s1;
        logic                  line_s2;
        logic                  line_s3;
        logic                  rec_s1;
        logic                  rec_s2;
        logic                  rec_s3;
        logic                  ref_s1;
        logic                  ref_s2;
        logic                  ref_s3;
        logic [7:0]            opmode_r;
        logic [7:0]            txcfg_r;
        logic [7:0]            mnt_sw_r;
        logic [ETXF_CNT_W-1:0] bit_cnt_r;
        logic                  frame_start_r;
        logic                  fbe_r;
        logic                  fbe_out_r;
        logic [7:0]            mnt_hold_r;
        logic                  mnt_pend_r;
        logic                  ovr_r;
        logic                  loop_r;
        logic [31:0]           addr_r;
        logic                  wr_pend_r;
        logic                  rd_pend_r;
        logic [31:0]           hrdata_r;
        logic                  hready_r;
    } etxf_core_s;

    etxf_core_s r;
    etxf_core_s n;

    etxf_strm_if #(.W(8)) strm ();

    etxf_tsel_e tsel;
    logic       line_rise;
    logic       rec_rise;
    logic       ref_rise;
    logic       tick;
    logic       restart;
    logic       wrap;
    logic       auto_mode;
    logic [7:0] mnt_byte;
    logic       bus_req;

    // ------------------------------------------------------------------
    // edge detection after two-flop synchronisers
    // ------------------------------------------------------------------
    assign line_rise = r.line_s2 && !r.line_s3;
    assign rec_rise  = r.rec_s2 && !r.rec_s3;
    assign ref_rise  = r.ref_s2 && !r.ref_s3;

    assign tsel      = etxf_tsel_e'(r.opmode_r[1:0]);
    assign auto_mode = r.txcfg_r[ETXF_AUTO_BIT];

    // tick source per timing mode
    always_comb begin
        case (tsel)
            ETXF_TSEL_LOOP: tick = rec_rise;
            ETXF_TSEL_FREF: tick = line_rise;
            ETXF_TSEL_FREE: tick = line_rise;
            default:        tick = line_rise;
        endcase
    end

    // reference only counts in its own mode; other modes ignore the pin
    assign restart = ref_rise && (tsel == ETXF_TSEL_FREF);
    assign wrap    = tick && (r.bit_cnt_r == ETXF_LAST_BIT);

    // ------------------------------------------------------------------
    // outbound maintenance byte
    // ------------------------------------------------------------------
    always_comb begin
        if (auto_mode) begin
            mnt_byte = {r.mnt_sw_r[7:3], r.fbe_r, r.mnt_sw_r[1:0]};
        end else begin
            mnt_byte = {r.mnt_sw_r[7:3], r.mnt_sw_r[ETXF_SWFBE_BIT], r.mnt_sw_r[1:0]};
        end
    end

    assign bus_req = i_hsel && i_hready && (i_htrans == ETXF_HTRANS_NSEQ);

    function automatic logic [31:0] rd_word(input etxf_core_s s, input logic [31:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            ETXF_A_OPMODE: w = {24'h000000, s.opmode_r};
            ETXF_A_TXCFG:  w = {24'h000000, s.txcfg_r};
            ETXF_A_MNT:    w = {24'h000000, s.mnt_sw_r};
            ETXF_A_STAT:   w = {24'h000000, 2'b00, s.opmode_r[1:0], s.loop_r, s.mnt_pend_r, s.ovr_r, s.fbe_r};
            default:       w = 32'h0000_0000;
        endcase
        return w;
    endfunction : rd_word

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.line_s1 = i_tx_line_clock_in;
        n.line_s2 = r.line_s1;
        n.line_s3 = r.line_s2;
        n.rec_s1  = i_rx_recovered_clock;
        n.rec_s2  = r.rec_s1;
        n.rec_s3  = r.rec_s2;
        n.ref_s1  = i_tx_frame_sync_in;
        n.ref_s2  = r.ref_s1;
        n.ref_s3  = r.ref_s2;
        n.frame_start_r = 1'b0;
        // bus: writes take no wait state, reads take one
        n.wr_pend_r = 1'b0;
        n.rd_pend_r = 1'b0;
        n.hready_r  = 1'b1;
        if (r.rd_pend_r) begin
            n.hrdata_r = rd_word(r, r.addr_r);
        end
        if (r.wr_pend_r) begin
            case (r.addr_r)
                ETXF_A_OPMODE: n.opmode_r = i_hwdata[7:0];
                ETXF_A_TXCFG:  n.txcfg_r  = i_hwdata[7:0] & ETXF_TXCFG_WMSK;
                ETXF_A_MNT:    n.mnt_sw_r = i_hwdata[7:0];
                ETXF_A_STAT: begin
                    if (i_hwdata[ETXF_OVR_BIT]) begin
                        n.ovr_r = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (bus_req) begin
            n.addr_r    = i_haddr;
            n.wr_pend_r = i_hwrite;
            n.rd_pend_r = !i_hwrite;
            n.hready_r  = i_hwrite;
        end
        // frame timing
        n.loop_r = (tsel == ETXF_TSEL_LOOP);
        if (restart || wrap) begin
            n.bit_cnt_r     = '0;
            n.frame_start_r = 1'b1;
        end else if (tick) begin
            n.bit_cnt_r = r.bit_cnt_r + 13'h0001;
        end
        // latest receive result is held until the next outbound frame
        if (i_rx_errmon_done) begin
            n.fbe_r = i_rx_errmon_err;
        end
        if (r.mnt_pend_r && strm.ready) begin
            n.mnt_pend_r = 1'b0;
        end
        // set after clear: an overrun in the clearing cycle is kept
        if (restart || wrap) begin
            if (r.mnt_pend_r && !strm.ready) begin
                n.ovr_r = 1'b1;
            end
            n.mnt_pend_r = 1'b1;
            n.mnt_hold_r = mnt_byte;
            n.fbe_out_r  = mnt_byte[ETXF_FBE_BIT];
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r          <= '0;
            r.opmode_r <= ETXF_OPMODE_RST;
            r.txcfg_r  <= ETXF_TXCFG_RST;
            r.mnt_sw_r <= ETXF_MNT_RST;
            r.hready_r <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // output buffer and ports
    // ------------------------------------------------------------------
    assign strm.valid = r.mnt_pend_r;
    assign strm.data  = r.mnt_hold_r;

    etxf_buf2 #(.W(8)) u_buf (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .s_in      (strm),
        .o_valid   (o_mnt_valid),
        .o_data    (o_maintenance_byte),
        .i_ready   (i_mnt_ready)
    );

    assign o_hrdata                  = r.hrdata_r;
    assign o_hreadyout               = r.hready_r;
    assign o_hresp                   = 1'b0;
    assign o_frame_start             = r.frame_start_r;
    assign o_bit_count               = r.bit_cnt_r;
    assign o_far_end_block_error_bit = r.fbe_out_r;
    assign o_timing_loop             = r.loop_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    sequence seq_rd_req;
        bus_req && !i_hwrite;
    endsequence

    sequence seq_rd_ans;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    sequence seq_frame_auto;
        (restart || wrap) && auto_mode;
    endsequence

    chk_read_wait_state: assert property (seq_rd_req |=> seq_rd_ans)
        else $error("read answer not after one wait state");
    chk_auto_fbe_follow: assert property (i_rx_errmon_done |=> r.fbe_r == $past(i_rx_errmon_err))
        else $error("far-end error did not follow receive result");
    chk_auto_mnt_byte: assert property (seq_frame_auto |=> o_far_end_block_error_bit == $past(r.fbe_r))
        else $error("automatic far-end error bit wrong");
    chk_manual_mnt_byte: assert property ((restart || wrap) && !auto_mode
        |=> r.mnt_hold_r[7:3] == $past(r.mnt_sw_r[7:3]) && r.mnt_hold_r[1:0] == $past(r.mnt_sw_r[1:0]))
        else $error("software maintenance byte not inserted");
    chk_manual_bit_map: assert property ((restart || wrap) && !auto_mode
        |=> o_far_end_block_error_bit == $past(r.mnt_sw_r[6]))
        else $error("software bit 6 not mapped to bit 2");
    chk_fref_restart: assert property (ref_rise && tsel == ETXF_TSEL_FREF
        |=> o_frame_start && o_bit_count == 13'h0000)
        else $error("reference edge did not restart frame");
    chk_free_holds: assert property (tsel == ETXF_TSEL_FREE && !line_rise |=> $stable(o_bit_count))
        else $error("free-run count moved without a line tick");
    chk_loop_counts: assert property (tsel == ETXF_TSEL_LOOP && rec_rise && !wrap
        |=> o_bit_count == $past(o_bit_count) + 13'h0001)
        else $error("loop timing count missed a recovered tick");
    chk_tsel_decode: assert property (1'b1 |=> o_timing_loop == ($past(r.opmode_r[1:0]) == 2'b00))
        else $error("loop timing output disagrees with select");
    chk_ref_once: assert property (ref_rise |=> !ref_rise ##1 !ref_rise)
        else $error("one reference edge seen twice");
endmodule : etxf_core

/* File: verilog/etxf_pkg.sv */
/*
 * constants, register map and types of the e3 transmit framer timing block.
 * assumes one 250 mhz system clock and a 32-bit ahb-lite register port.
 */
package etxf_pkg;
    // ------------------------------------------------------------------
    // register indices and byte addresses (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [15:0] ETXF_IDX_OPMODE = 16'h1100;
    localparam logic [15:0] ETXF_IDX_TXCFG  = 16'h1130;
    localparam logic [15:0] ETXF_IDX_STAT   = 16'h1131;
    localparam logic [15:0] ETXF_IDX_MNT    = 16'h1136;
    localparam logic [31:0] ETXF_A_OPMODE   = {14'h0000, ETXF_IDX_OPMODE, 2'b00};
    localparam logic [31:0] ETXF_A_TXCFG    = {14'h0000, ETXF_IDX_TXCFG, 2'b00};
    localparam logic [31:0] ETXF_A_STAT     = {14'h0000, ETXF_IDX_STAT, 2'b00};
    localparam logic [31:0] ETXF_A_MNT      = {14'h0000, ETXF_IDX_MNT, 2'b00};
    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  ETXF_OPMODE_RST = 8'h2b;
    localparam logic [7:0]  ETXF_TXCFG_RST  = 8'h00;
    localparam logic [7:0]  ETXF_TXCFG_WMSK = 8'h17;
    localparam logic [7:0]  ETXF_MNT_RST    = 8'h00;
    localparam int          ETXF_AUTO_BIT   = 0;
    localparam int          ETXF_SWFBE_BIT  = 6;
    localparam int          ETXF_FBE_BIT    = 2;
    localparam int          ETXF_OVR_BIT    = 1;
    // ------------------------------------------------------------------
    // frame length in ticks of the selected clock (line, or recovered in loop timing)
    // ------------------------------------------------------------------
    localparam int          ETXF_FRAME_BYTES = 537;
    localparam int          ETXF_CNT_W       = 13;
    localparam logic [12:0] ETXF_LAST_BIT    = 13'(ETXF_FRAME_BYTES * 8 - 1);
    localparam logic [1:0]  ETXF_HTRANS_NSEQ = 2'b10;

    typedef enum logic [1:0] {
        ETXF_TSEL_LOOP = 2'b00,
        ETXF_TSEL_FREF = 2'b01,
        ETXF_TSEL_RSVD = 2'b10,
        ETXF_TSEL_FREE = 2'b11
    } etxf_tsel_e;
endpackage : etxf_pkg

/* File: verilog/etxf_strm_if.sv */
/*
 * valid/ready byte stream between the framer core and its output buffer.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
interface etxf_strm_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : etxf_strm_if

/* File: verilog/etxf_buf2.sv */
/*
 * two-entry buffer, head always in slot 0 so the outputs come from flops.
 * assumes the sink may hold i_ready low for any time.
 */
`timescale 1ns/100ps
module etxf_buf2 #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_reset_n,
    // fill side
    etxf_strm_if.snk          s_in,
    // drain side
    output logic              o_valid,
    output logic [W-1:0]      o_data,
    input  wire logic         i_ready
);
    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic         v0;
        logic         v1;
    } etxf_buf_s;

    etxf_buf_s r;
    etxf_buf_s n;
    logic      push;
    logic      pop;

    assign push = s_in.valid && !r.v1;
    assign pop  = i_ready && r.v0;

    always_comb begin
        n = r;
        if (pop) begin
            n.d0 = r.v1 ? r.d1 : s_in.data;
            n.v0 = r.v1 || push;
            n.d1 = s_in.data;
            n.v1 = r.v1 && push;
        end else if (push) begin
            if (!r.v0) begin
                n.d0 = s_in.data;
                n.v0 = 1'b1;
            end else begin
                n.d1 = s_in.data;
                n.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // full stalls the source instead of dropping a word
    assign s_in.ready = !r.v1;
    assign o_valid    = r.v0;
    assign o_data     = r.d0;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    chk_buf_first_word: assert property (push && !r.v0 |=> o_valid && o_data == $past(s_in.data))
        else $error("buffer lost a word into an empty slot");
    chk_buf_hold_stall: assert property (o_valid && !i_ready |=> o_valid && $stable(o_data))
        else $error("buffer head changed while stalled");
endmodule : etxf_buf2

/* File: dv/etxf_far_end.sv */
/*
 * far-end model: line and recovered clocks, frame reference, error-monitor results, byte sink.
 * assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/100ps
module etxf_far_end (
    // system side
    input  wire logic i_mclk,
    input  wire logic i_stall,
    // pins toward the block
    output logic      o_line_clk,
    output logic      o_rec_clk,
    output logic      o_frame_ref,
    output logic      o_errmon_done,
    output logic      o_errmon_err,
    output logic      o_ready
);
    int lcnt = 0;
    int rcnt = 0;

    initial begin
        o_line_clk  = 1'b0;
        o_rec_clk   = 1'b0;
        o_frame_ref   = 1'b0;
        o_errmon_done = 1'b0;
        o_errmon_err  = 1'b0;
        o_ready     = 1'b0;
    end

    // ----------------------------------------------------------------
    // clocks: scaled rates, distinct so the chosen source shows
    // ----------------------------------------------------------------
    always @(posedge i_mclk) begin
        lcnt <= (lcnt == 2) ? 0 : lcnt + 1;
        rcnt <= (rcnt == 3) ? 0 : rcnt + 1;
        if (lcnt == 2) begin
            o_line_clk <= ~o_line_clk;
        end
        if (rcnt == 3) begin
            o_rec_clk <= ~o_rec_clk;
        end
        // slow sink: takes a byte every other cycle at best
        o_ready <= i_stall ? 1'b0 : ~o_ready;
    end

    // reference rises with a line clock edge, so both stay in step
    // bounded: a missed alignment shows up as a wrong frame count in the bench
    task automatic send_ref(input int p);
        int k;
        k = 0;
        do begin @(posedge i_mclk); k++; end while (!(lcnt == 2 && !o_line_clk) && k < 8);
        o_frame_ref <= 1'b1;
        repeat (p * 6) @(posedge i_mclk);
        o_frame_ref <= 1'b0;
    endtask : send_ref

    task automatic send_errmon(input logic err);
        @(posedge i_mclk);
        o_errmon_done <= 1'b1;
        o_errmon_err  <= err;
        @(posedge i_mclk);
        o_errmon_done <= 1'b0;
        o_errmon_err  <= ~err;
    endtask : send_errmon
endmodule : etxf_far_end

/* File: dv/tb_e3_tx_framer_timing_ref_select.sv */
/*
 * self-checking bench of etxf_core with the far-end model.
 * assumes hready loops back from hreadyout and one slave on the bus.
 */
`timescale 1ns/100ps
module tb_e3_tx_framer_timing_ref_select;
    import etxf_pkg::*;
    typedef struct {logic wr; logic [31:0] a; logic [31:0] d;} etxf_row_s;
    typedef struct {logic au; logic [7:0] sw; logic er; logic [7:0] ex;} etxf_byte_s;
    localparam logic [31:0] A_BAD = 32'h0000_0100;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic        stall = 1'b0;
    logic [31:0] rd, hrdata;
    logic        hready, hresp, fstart, fbe, loop_o, mvalid, ready, lclk, rclk, fref, emd, eme;
    logic [7:0]  mbyte;
    logic [12:0] bcnt, z;
    logic [7:0]  got_q[$];
    int          n_errors = 0;
    int          samples_checked = 0;
    int          n, g;
    logic [1:0]  tsel_t[4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    etxf_row_s   rows[13] = '{'{0, ETXF_A_OPMODE, 32'h2b}, '{0, ETXF_A_TXCFG, 0}, '{0, ETXF_A_MNT, 0},
        '{0, ETXF_A_STAT, 32'h30}, '{0, A_BAD, 0}, '{1, ETXF_A_TXCFG, 32'hff}, '{0, ETXF_A_TXCFG, 32'h17},
        '{1, ETXF_A_MNT, 32'h1234_565a}, '{0, ETXF_A_MNT, 32'h5a}, '{1, A_BAD, 32'hff}, '{0, A_BAD, 0},
        '{1, ETXF_A_OPMODE, 32'h29}, '{0, ETXF_A_OPMODE, 32'h29}};
    etxf_byte_s  bt[6] = '{'{0, 8'h40, 0, 8'h44}, '{0, 8'hbf, 1, 8'hbb}, '{1, 8'h00, 1, 8'h04},
        '{1, 8'h00, 0, 8'h00}, '{1, 8'hbb, 1, 8'hbf}, '{1, 8'hbb, 0, 8'hbb}};

    always #2 mclk = ~mclk;

    etxf_core DUT (.i_mclk(mclk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_tx_line_clock_in(lclk), .i_rx_recovered_clock(rclk),
        .i_tx_frame_sync_in(fref), .i_rx_errmon_done(emd), .i_rx_errmon_err(eme), .o_frame_start(fstart),
        .o_bit_count(bcnt), .o_far_end_block_error_bit(fbe), .o_timing_loop(loop_o),
        .o_mnt_valid(mvalid), .o_maintenance_byte(mbyte), .i_mnt_ready(ready));
    etxf_far_end far (.i_mclk(mclk), .i_stall(stall), .o_line_clk(lclk), .o_rec_clk(rclk),
        .o_frame_ref(fref), .o_errmon_done(emd), .o_errmon_err(eme), .o_ready(ready));

    always @(posedge mclk) begin
        if (mvalid === 1'b1 && ready === 1'b1) got_q.push_back(mbyte);
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic give_up;
        n_errors++;
        wrap_up();
    endtask : give_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_ready;
        int k;
        k = 0;
        do begin @(posedge mclk); k++; end while (hready !== 1'b1 && k < 50);
        if (k >= 50) give_up();
    endtask : wait_ready

    // one single transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= ETXF_HTRANS_NSEQ;
        haddr  <= a;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        chk(hresp, 0);
    endtask : ahb

    task automatic tick_gap(output int c);
        logic [12:0] b;
        b = bcnt;
        c = 0;
        do begin @(posedge mclk); c++; end while (bcnt === b && c < 40);
        if (c >= 40) give_up();
    endtask : tick_gap

    task automatic count_fs(input int lim, output int c);
        c = 0;
        repeat (lim) begin
            @(posedge mclk);
            if (fstart === 1'b1) begin
                c++;
                z = bcnt;
            end
        end
    endtask : count_fs

    task automatic frame(input int p, input int e);
        int c;
        z = '1;
        fork far.send_ref(p); count_fs(p * 6 + 40, c); join
        chk(c, e);
        if (e == 1) chk(z, 0);
    endtask : frame

    task automatic wait_byte;
        int k;
        k = 0;
        do begin @(posedge mclk); k++; end while (got_q.size() == 0 && k < 40);
        if (k >= 40) give_up();
    endtask : wait_byte

    task automatic do_reset;
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
    endtask : do_reset

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        foreach (rows[i]) begin
            ahb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(rd, rows[i].d);
        end
        foreach (tsel_t[i]) begin
            ahb(1, ETXF_A_OPMODE, {24'h0, 6'h0a, tsel_t[i]});
            repeat (20) @(posedge mclk);
            chk(loop_o, tsel_t[i] == 2'b00);
            ahb(0, ETXF_A_STAT, 0);
            chk(rd & 32'h38, {26'h0, tsel_t[i], tsel_t[i] == 2'b00, 3'b000});
            tick_gap(g);
            tick_gap(g);
            chk(g, (tsel_t[i] == 2'b00) ? 8 : 6);
        end
        ahb(1, ETXF_A_OPMODE, 32'h29);
        frame(8, 1);
        // auto mode with no receive result yet: stored byte goes out with a clear error bit
        wait_byte();
        chk(got_q.pop_front(), 32'h5a);
        foreach (bt[i]) begin
            ahb(1, ETXF_A_TXCFG, {31'h0, bt[i].au});
            ahb(1, ETXF_A_MNT, {24'h0, bt[i].sw});
            far.send_errmon(bt[i].er);
            frame(2, 1);
            wait_byte();
            chk(got_q.pop_front(), bt[i].ex);
            chk(fbe, bt[i].ex[2]);
            ahb(0, ETXF_A_STAT, 0);
            chk(rd[0], bt[i].er);
        end
        // stalled sink: two in the buffer, one pending, the fourth overwrites it
        @(posedge mclk);
        stall <= 1'b1;
        ahb(1, ETXF_A_TXCFG, 0);
        for (int i = 0; i < 4; i++) begin
            ahb(1, ETXF_A_MNT, 32'h10 + i);
            frame(2, 1);
        end
        chk(got_q.size(), 0);
        chk(mvalid, 1);
        ahb(0, ETXF_A_STAT, 0);
        chk(rd & 32'h6, 32'h6);
        @(posedge mclk);
        stall <= 1'b0;
        repeat (30) @(posedge mclk);
        chk(got_q.size(), 3);
        chk(got_q.pop_front(), 32'h10);
        chk(got_q.pop_front(), 32'h11);
        chk(got_q.pop_front(), 32'h13);
        ahb(0, ETXF_A_STAT, 0);
        chk(rd & 32'h6, 32'h2);
        ahb(1, ETXF_A_STAT, 32'h2);
        ahb(0, ETXF_A_STAT, 0);
        chk(rd & 32'h6, 32'h0);
        // second reset mid-run, then free-run ignores the reference
        do_reset();
        ahb(0, ETXF_A_OPMODE, 0);
        chk(rd, 32'h2b);
        frame(1, 0);
        n = 0;
        do begin @(posedge mclk); n++; end while (bcnt !== ETXF_LAST_BIT && n < 27000);
        if (n >= 27000) give_up();
        count_fs(12, g);
        chk(g, 1);
        chk(z, 0);
        wrap_up();
    end
endmodule : tb_e3_tx_framer_timing_ref_select
